// file: design/mirse_host.sv
// Serial flash host: Wishbone command registers driving a multi-line flash.
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mirse_regs.svh"

module mirse_host
   import mirse_pkg::*;
#(
   parameter int SCLK_HALF = 4,
   parameter logic [7:0] WRITE_ENABLE_COMMAND_OPCODE = 8'h06,
   parameter logic [7:0] RDSR_OPCODE = 8'h05,
   parameter logic [7:0] BURST_OPCODE = 8'h77
)
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic flash_cs_n_o,
   output logic flash_sclk_o,
   input wire logic [3:0] data_line_i,
   output logic [3:0] data_line_o,
   output logic [3:0] data_line_oe_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Lines a phase of the given width drives, lowest line first.
   function automatic logic [3:0] lane_mask(input logic [2:0] w);
      logic [3:0] m;
      m = 4'h1;
      if (w == 3'd2)
      begin
         m = 4'h3;
      end
      else if (w == 3'd4)
      begin
         m = 4'hf;
      end
      return m;
   endfunction

   // Top bits of the shift word placed on the lines, highest bit on top line.
   function automatic logic [3:0] lane_bits(input logic [31:0] tx,
                                            input logic [2:0] w);
      logic [3:0] b;
      b = {3'h0, tx[31]};
      if (w == 3'd2)
      begin
         b = {2'h0, tx[31:30]};
      end
      else if (w == 3'd4)
      begin
         b = tx[31:28];
      end
      return b;
   endfunction

   // Indicator halves complement each other bit by bit.
   function automatic logic is_toggling(input logic [7:0] ind);
      return (ind[7:4] == ~ind[3:0]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers and state.

   mirse_state_t state_q;
   mirse_cmd_t op_q;
   logic [1:0] len_q;
   logic cont_req_q;
   logic dc_q;
   logic [23:0] addr_q;
   logic [7:0] wrap_q;
   logic qe_q;
   logic [31:0] rdata_q;
   logic err_q;
   logic done_q;
   logic start_q;
   logic cont_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [7:0] div_q;
   logic sclk_q;
   logic cs_n_q;
   logic [5:0] left_q;
   logic [2:0] w_q;
   logic [31:0] tx_q;
   logic [31:0] rx_q;
   logic [3:0] dout_q;
   logic [3:0] oe_q;

   logic busy;
   logic div_end;
   logic rise_e;
   logic fall_e;
   logic wb_req;
   mirse_state_t nxt_c;
   logic [5:0] ph_n;
   logic [2:0] ph_w;
   logic [31:0] ph_tx;
   logic [7:0] opcode_c;
   logic [7:0] ind_c;
   logic [5:0] bytes_bits;
   logic [5:0] dual_dummy;
   logic [5:0] quad_dummy;

   assign busy = (state_q != MIRSE_IDLE) || start_q;
   assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
   assign div_end = (div_q == 8'(SCLK_HALF - 1));
   assign rise_e = div_end && !sclk_q;
   assign fall_e = div_end && sclk_q;
   assign ind_c = cont_req_q ? `MIRSE_IND_STAY : `MIRSE_IND_LEAVE;
   assign bytes_bits = 6'(({4'h0, len_q} + 6'd1) << 3);
   // Totals include the two mode clocks driven before the quiet dummies.
   assign dual_dummy = (dc_q ? `MIRSE_DUAL_DUMMY_LONG
                        : `MIRSE_DUAL_DUMMY_SHORT) - `MIRSE_MODE_CLKS;
   assign quad_dummy = (dc_q ? `MIRSE_QUAD_DUMMY_LONG
                        : `MIRSE_QUAD_DUMMY_SHORT) - `MIRSE_MODE_CLKS;

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave: one-cycle answer, unmapped reads zero, writes dropped.

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end
      else
      begin
         ack_q <= wb_req;
         if (wb_req && !wb_we_i)
         begin
            if (wb_adr_i == `MIRSE_ADDR_OFS)
            begin
               dat_q <= {8'h0, addr_q};
            end
            else if (wb_adr_i == `MIRSE_WRAP_OFS)
            begin
               dat_q <= {24'h0, wrap_q};
            end
            else if (wb_adr_i == `MIRSE_CFG_OFS)
            begin
               dat_q <= {31'h0, qe_q};
            end
            else if (wb_adr_i == `MIRSE_RDATA_OFS)
            begin
               dat_q <= rdata_q;
            end
            else if (wb_adr_i == `MIRSE_STAT_OFS)
            begin
               dat_q <= {28'h0, done_q, err_q, cont_q, busy};
            end
            else if (wb_adr_i == `MIRSE_CTRL_OFS)
            begin
               dat_q <= {22'h0, dc_q, cont_req_q, 2'h0, len_q, 1'b0, op_q};
            end
            else
            begin
               dat_q <= 32'h0;
            end
         end
      end
   end

   // Register writes; a command word starts the engine when legal.
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         op_q <= MIRSE_CMD_DUAL;
         len_q <= 2'h0;
         cont_req_q <= 1'b0;
         dc_q <= 1'b0;
         addr_q <= 24'h0;
         wrap_q <= 8'h10;
         qe_q <= 1'b0;
         err_q <= 1'b0;
         start_q <= 1'b0;
      end
      else
      begin
         start_q <= 1'b0;
         if (wb_req && wb_we_i)
         begin
            if (wb_adr_i == `MIRSE_ADDR_OFS && wb_sel_i[0])
            begin
               addr_q <= wb_dat_i[23:0];
            end
            else if (wb_adr_i == `MIRSE_WRAP_OFS && wb_sel_i[0])
            begin
               wrap_q <= wb_dat_i[7:0];
            end
            else if (wb_adr_i == `MIRSE_CFG_OFS && wb_sel_i[0])
            begin
               qe_q <= wb_dat_i[0];
            end
            else if (wb_adr_i == `MIRSE_CTRL_OFS && (&wb_sel_i[1:0]))
            begin
               // Refuse while busy, an unknown code, a quad read without
               // quad enable, or anything but a quad address read while the
               // device sits in continuous read and would take it as address.
               if (busy || wb_dat_i[2:0] == 3'h7
                   || (!qe_q && (wb_dat_i[2:0] == MIRSE_CMD_QOUT
                       || wb_dat_i[2:0] == MIRSE_CMD_QADDR))
                   || (cont_q && wb_dat_i[2:0] != MIRSE_CMD_QADDR))
               begin
                  err_q <= 1'b1;
               end
               else
               begin
                  op_q <= mirse_cmd_t'(wb_dat_i[2:0]);
                  len_q <= wb_dat_i[`MIRSE_CTRL_LEN_LSB +: 2];
                  cont_req_q <= wb_dat_i[`MIRSE_CTRL_CONT_BIT];
                  dc_q <= wb_dat_i[`MIRSE_CTRL_DC_BIT];
                  err_q <= 1'b0;
                  start_q <= 1'b1;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin input synchroniser.

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end
      else
      begin
         sync1_q <= data_line_i;
         sync2_q <= sync1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Phase sequencing and the setup of the phase about to begin.

   always_comb
   begin
      case (op_q)
         MIRSE_CMD_DUAL: opcode_c = `MIRSE_OP_DUAL_READ;
         MIRSE_CMD_QOUT: opcode_c = `MIRSE_OP_QUAD_OUT;
         MIRSE_CMD_QADDR: opcode_c = `MIRSE_OP_QUAD_ADDR;
         MIRSE_CMD_BURST: opcode_c = BURST_OPCODE;
         MIRSE_CMD_ERASE: opcode_c = `MIRSE_OP_SECTOR_ERASE;
         MIRSE_CMD_WRITE_ENABLE_COMMAND: opcode_c = WRITE_ENABLE_COMMAND_OPCODE;
         default: opcode_c = RDSR_OPCODE;
      endcase
   end

   always_comb
   begin
      case (state_q)
         MIRSE_IDLE: nxt_c = (op_q == MIRSE_CMD_QADDR && cont_q)
                             ? MIRSE_ADDR : MIRSE_CMD;
         MIRSE_CMD: nxt_c = (op_q == MIRSE_CMD_WRITE_ENABLE_COMMAND) ? MIRSE_TAIL
                            : (op_q == MIRSE_CMD_RDSR) ? MIRSE_DATA
                            : MIRSE_ADDR;
         MIRSE_ADDR: nxt_c = (op_q == MIRSE_CMD_ERASE
                              || op_q == MIRSE_CMD_BURST) ? MIRSE_TAIL
                             : (op_q == MIRSE_CMD_QOUT) ? MIRSE_DUMMY
                             : MIRSE_MODE;
         MIRSE_MODE: nxt_c = MIRSE_DUMMY;
         MIRSE_DUMMY: nxt_c = MIRSE_DATA;
         MIRSE_DATA: nxt_c = MIRSE_TAIL;
         default: nxt_c = MIRSE_IDLE;
      endcase
   end

   // Clock count, lane width and shift word of the next phase.
   always_comb
   begin
      ph_n = 6'd0;
      ph_w = 3'd1;
      ph_tx = 32'h0;
      case (nxt_c)
         MIRSE_CMD:
         begin
            ph_n = `MIRSE_OPCODE_CLKS;
            ph_tx = {opcode_c, 24'h0};
         end
         MIRSE_ADDR:
         begin
            ph_tx = {addr_q, 8'h0};
            if (op_q == MIRSE_CMD_BURST)
            begin
               ph_n = `MIRSE_OPCODE_CLKS;
               ph_tx = {wrap_q, 24'h0};
            end
            else if (op_q == MIRSE_CMD_DUAL)
            begin
               ph_n = `MIRSE_ADDR2_CLKS;
               ph_w = 3'd2;
            end
            else if (op_q == MIRSE_CMD_QADDR)
            begin
               ph_n = `MIRSE_ADDR4_CLKS;
               ph_w = 3'd4;
            end
            else
            begin
               ph_n = `MIRSE_ADDR1_CLKS;
            end
         end
         MIRSE_MODE:
         begin
            ph_n = `MIRSE_MODE_CLKS;
            if (op_q == MIRSE_CMD_DUAL)
            begin
               ph_w = 3'd2;
            end
            else
            begin
               ph_w = 3'd4;
               ph_tx = {ind_c, 24'h0};
            end
         end
         MIRSE_DUMMY:
         begin
            if (op_q == MIRSE_CMD_QOUT)
            begin
               ph_n = `MIRSE_QOUT_DUMMY;
            end
            else if (op_q == MIRSE_CMD_DUAL)
            begin
               ph_n = dual_dummy;
            end
            else
            begin
               ph_n = quad_dummy;
            end
         end
         MIRSE_DATA:
         begin
            if (op_q == MIRSE_CMD_RDSR)
            begin
               ph_n = `MIRSE_OPCODE_CLKS;
            end
            else if (op_q == MIRSE_CMD_DUAL)
            begin
               ph_w = 3'd2;
               ph_n = bytes_bits >> 1;
            end
            else
            begin
               ph_w = 3'd4;
               ph_n = bytes_bits >> 2;
            end
         end
         default:
         begin
            ph_n = 6'd0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial clock divider; it restarts whenever the engine is idle.

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         div_q <= 8'h0;
      end
      else if (state_q == MIRSE_IDLE || div_end)
      begin
         div_q <= 8'h0;
      end
      else
      begin
         div_q <= div_q + 8'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame engine. Host lines change on falling edges so that the device
   // samples them settled on the rising edge; read data is taken on the
   // rising edge, half a clock after the device moved it.

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_q <= MIRSE_IDLE;
         cs_n_q <= 1'b1;
         sclk_q <= 1'b0;
         left_q <= 6'd0;
         w_q <= 3'd1;
         tx_q <= 32'h0;
         rx_q <= 32'h0;
         dout_q <= 4'h0;
         oe_q <= 4'h0;
         rdata_q <= 32'h0;
         cont_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            MIRSE_IDLE:
            begin
               if (start_q)
               begin
                  state_q <= nxt_c;
                  cs_n_q <= 1'b0;
                  done_q <= 1'b0;
                  rx_q <= 32'h0;
                  left_q <= ph_n;
                  w_q <= ph_w;
                  tx_q <= ph_tx;
                  dout_q <= lane_bits(ph_tx, ph_w);
                  oe_q <= lane_mask(ph_w);
               end
            end
            MIRSE_TAIL:
            begin
               // Select stays high at least half a serial clock.
               if (div_end)
               begin
                  state_q <= MIRSE_IDLE;
                  done_q <= 1'b1;
               end
            end
            default:
            begin
               if (rise_e)
               begin
                  sclk_q <= 1'b1;
                  left_q <= left_q - 6'd1;
                  if (state_q == MIRSE_DATA)
                  begin
                     if (w_q == 3'd4)
                     begin
                        rx_q <= {rx_q[27:0], sync2_q};
                     end
                     else if (w_q == 3'd2)
                     begin
                        rx_q <= {rx_q[29:0], sync2_q[1:0]};
                     end
                     else
                     begin
                        rx_q <= {rx_q[30:0], sync2_q[1]};
                     end
                  end
               end
               else if (fall_e)
               begin
                  sclk_q <= 1'b0;
                  if (left_q == 6'd0)
                  begin
                     if (state_q == MIRSE_MODE && op_q == MIRSE_CMD_QADDR)
                     begin
                        cont_q <= is_toggling(ind_c);
                     end
                     if (state_q == MIRSE_DATA)
                     begin
                        rdata_q <= rx_q;
                     end
                     // Select rises right after the last bit of the frame.
                     cs_n_q <= (nxt_c == MIRSE_TAIL);
                     state_q <= nxt_c;
                     left_q <= ph_n;
                     w_q <= ph_w;
                     tx_q <= ph_tx;
                     dout_q <= lane_bits(ph_tx, ph_w);
                     // Lines are released from the dummy phase on.
                     oe_q <= (nxt_c == MIRSE_DUMMY || nxt_c == MIRSE_DATA
                              || nxt_c == MIRSE_TAIL)
                             ? 4'h0 : lane_mask(ph_w);
                  end
                  else
                  begin
                     tx_q <= tx_q << w_q;
                     dout_q <= lane_bits(tx_q << w_q, w_q);
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, each straight from a register.

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign flash_cs_n_o = cs_n_q;
   assign flash_sclk_o = sclk_q;
   assign data_line_o = dout_q;
   assign data_line_oe_o = oe_q;

endmodule
`default_nettype wire

// file: common/mirse_regs.svh
// Register offsets, opcodes, field positions and timing counts of the flash host.
`ifndef MIRSE_REGS_SVH
`define MIRSE_REGS_SVH

// Wishbone byte offsets.
`define MIRSE_CTRL_OFS 6'h00
`define MIRSE_ADDR_OFS 6'h04
`define MIRSE_WRAP_OFS 6'h08
`define MIRSE_CFG_OFS 6'h0c
`define MIRSE_RDATA_OFS 6'h10
`define MIRSE_STAT_OFS 6'h14

// Control word fields.
`define MIRSE_CTRL_OP_LSB 0
`define MIRSE_CTRL_LEN_LSB 4
`define MIRSE_CTRL_CONT_BIT 8
`define MIRSE_CTRL_DC_BIT 9

// Status word fields.
`define MIRSE_STAT_BUSY_BIT 0
`define MIRSE_STAT_CONT_BIT 1
`define MIRSE_STAT_ERR_BIT 2
`define MIRSE_STAT_DONE_BIT 3

// Opcodes printed for this block.
`define MIRSE_OP_DUAL_READ 8'hbb
`define MIRSE_OP_QUAD_OUT 8'h6b
`define MIRSE_OP_QUAD_ADDR 8'heb
`define MIRSE_OP_SECTOR_ERASE 8'h20

// Continuous read indicators: toggling to stay, all ones to leave.
`define MIRSE_IND_STAY 8'ha5
`define MIRSE_IND_LEAVE 8'hff

// Clock counts per phase.
`define MIRSE_OPCODE_CLKS 6'd8
`define MIRSE_ADDR1_CLKS 6'd24
`define MIRSE_ADDR2_CLKS 6'd12
`define MIRSE_ADDR4_CLKS 6'd6
`define MIRSE_MODE_CLKS 6'd2
`define MIRSE_QOUT_DUMMY 6'd8
`define MIRSE_DUAL_DUMMY_SHORT 6'd4
`define MIRSE_DUAL_DUMMY_LONG 6'd8
`define MIRSE_QUAD_DUMMY_SHORT 6'd6
`define MIRSE_QUAD_DUMMY_LONG 6'd10

`endif

// file: common/mirse_pkg.sv
// Types shared by the flash host: engine phases and command codes.
package mirse_pkg;

   // Gray coded along idle, opcode, address, mode, dummy, data, tail.
   typedef enum logic [2:0] {
      MIRSE_IDLE = 3'b000,
      MIRSE_CMD = 3'b001,
      MIRSE_ADDR = 3'b011,
      MIRSE_MODE = 3'b010,
      MIRSE_DUMMY = 3'b110,
      MIRSE_DATA = 3'b111,
      MIRSE_TAIL = 3'b101
   } mirse_state_t;

   typedef enum logic [2:0] {
      MIRSE_CMD_DUAL = 3'h0,
      MIRSE_CMD_QOUT = 3'h1,
      MIRSE_CMD_QADDR = 3'h2,
      MIRSE_CMD_BURST = 3'h3,
      MIRSE_CMD_ERASE = 3'h4,
      MIRSE_CMD_WRITE_ENABLE_COMMAND = 3'h5,
      MIRSE_CMD_RDSR = 3'h6
   } mirse_cmd_t;

endpackage

// file: dv/mirse_host_monitor.sv
// Port checker for the flash host, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module mirse_host_monitor #(parameter int SCLK_HALF = 4)
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic flash_cs_n_o,
   input wire logic flash_sclk_o,
   input wire logic [3:0] data_line_o,
   input wire logic [3:0] data_line_oe_o
);
   logic [7:0] hi_q;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   ////////////////////////////////////////////////////////////////////////
   // Counts high cycles of the serial clock; a stuck divider shows here.
   always_ff @(posedge core_clk_i or negedge reset_n_i)
      if (!reset_n_i)
         hi_q <= 8'h00;
      else
         hi_q <= flash_sclk_o ? hi_q + 8'h01 : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Bus answers exactly one cycle after a request and only for one cycle.
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   // Link timing: idle clock low, data moved at falling clock edges only.
   a_sclk_idle: assert property (flash_cs_n_o |-> !flash_sclk_o)
      else $error("clock moves while deselected");
   a_sclk_high: assert property ($fell(flash_sclk_o) |-> hi_q == SCLK_HALF)
      else $error("clock high phase wrong");
   a_line_fall: assert property (!flash_cs_n_o && !$fell(flash_cs_n_o)
      && $changed(data_line_o) |-> $fell(flash_sclk_o))
      else $error("line moved off a falling clock");
   a_cs_boundary: assert property ($rose(flash_cs_n_o) |-> $fell(flash_sclk_o))
      else $error("select rose off a clock boundary");
   a_cs_gap: assert property ($rose(flash_cs_n_o) |-> flash_cs_n_o[*4])
      else $error("select high too short");
   a_oe_quiet: assert property (flash_cs_n_o |-> data_line_oe_o == 4'h0)
      else $error("lines driven while deselected");
endmodule

bind mirse_host mirse_host_monitor #(.SCLK_HALF(SCLK_HALF)) mon_inst (
   .core_clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .flash_cs_n_o,
   .flash_sclk_o, .data_line_o, .data_line_oe_o);
`default_nettype wire

// file: dv/mirse_flash_model.sv
// Behavioural serial flash that answers the host's frames.
`timescale 1ns/1ps
`default_nettype none
module mirse_flash_model #(parameter int ERASE_CLKS = 200)
(
   input wire logic clk_i,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic [3:0] line_i,
   input wire logic long_dummy_i,
   output logic [3:0] line_o = 4'h0,
   output logic [3:0] oe_o = 4'h0
);
   logic [23:0] a, v;
   logic [7:0] op;
   logic [7:0] wrap = 8'h10;
   logic cont = 0, write_enable_latch = 0, write_in_progress = 0;
   int ln;

   ////////////////////////////////////////////////////////////////////////
   // Shifts in clks clocks of ln lines, sampled on rising clocks.
   task automatic take(input int clks);
      v = '0;
      repeat (clks)
      begin
         @(posedge sclk_i);
         v = (v << ln) | 24'(line_i & 4'((1 << ln) - 1));
      end
   endtask

   // Drives bytes on falling clocks until select rises, then lets go.
   task automatic emit(input int sh);
      int k;
      logic [7:0] b;
      logic [23:0] m;
      k = 0;
      forever
      begin
         @(negedge sclk_i or posedge cs_n_i);
         if (cs_n_i)
            break;
         m = 24'((8 << wrap[1:0]) - 1);
         if (k == 0)
         begin
            b = (op == 8'h05) ? {6'h00, write_enable_latch, write_in_progress} : a[7:0] ^ 8'h5a;
            k = 8;
            a = (op == 8'heb && !wrap[4]) ? (a & ~m) | ((a + 1) & m)
               : a + 24'h1;
         end
         k -= ln;
         oe_o = 4'(((1 << ln) - 1) << sh);
         line_o = 4'(((b >> k) & 8'((1 << ln) - 1)) << sh);
      end
      oe_o = 4'h0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // One frame per select low; continuous mode skips the opcode.
   always @(negedge cs_n_i)
   begin
      ln = cont ? 4 : 1;
      op = 8'heb;
      if (!cont)
      begin
         take(8);
         op = v[7:0];
      end
      ln = (op == 8'hbb) ? 2 : (op == 8'heb) ? 4 : 1;
      if (op inside {8'hbb, 8'h6b, 8'heb} && !write_in_progress)
      begin
         take(24 / ln);
         a = v;
         if (op == 8'heb)
         begin
            take(2);
            cont = v[7:4] == ~v[3:0];
         end
         repeat ((op == 8'h6b || long_dummy_i) ? 8 : 4)
            @(posedge sclk_i);
         if (op == 8'h6b)
            ln = 4;
         emit(0);
      end
      else if (op == 8'h06)
         write_enable_latch = 1'b1;
      else if (op == 8'h77)
      begin
         take(8);
         wrap = v[7:0];
      end
      else if (op == 8'h05)
         emit(1);
      else if (op == 8'h20)
      begin
         take(24);
         @(posedge cs_n_i or posedge sclk_i);
         if (cs_n_i && write_enable_latch && !write_in_progress)
            fork
               begin
                  write_in_progress = 1'b1;
                  repeat (ERASE_CLKS) @(posedge clk_i);
                  write_in_progress = 1'b0;
                  write_enable_latch = 1'b0;
               end
            join_none
      end
   end
endmodule
`default_nettype wire

// file: dv/test_mirse_host.sv
// Self-checking bench: the flash host against a behavioural flash.
`timescale 1ns/1ps
`default_nettype none
`include "mirse_regs.svh"
module test_mirse_host;
   logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ld = 0, tog = 0;
   logic [5:0] adr = 6'h00;
   logic [31:0] wd = 0, rd, dat;
   logic ack, cs_n, sclk;
   logic [3:0] ho, hoe, fo, foe, lw;
   int failures = 0, cmp_count = 0;

   mirse_host mirse_host_inst (.core_clk_i(clk), .reset_n_i(rst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack),
      .flash_cs_n_o(cs_n), .flash_sclk_o(sclk), .data_line_i(lw),
      .data_line_o(ho), .data_line_oe_o(hoe));
   mirse_flash_model mirse_flash_model_inst (.clk_i(clk), .cs_n_i(cs_n),
      .sclk_i(sclk), .line_i(lw), .long_dummy_i(ld), .line_o(fo),
      .oe_o(foe));

   // Undriven lines toggle so a stale value cannot pass for data.
   always @(posedge clk) tog <= ~tog;
   assign lw = (hoe & ho) | (~hoe & foe & fo) | (~hoe & ~foe & {4{tog}});
   initial forever #50 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   // One classic bus cycle, held until ack is seen.
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do @(posedge clk); while (ack !== 1'b1 && ++t < 20);
      if (ack !== 1'b1) failures++;
      rd = dat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic stat();
      wb(1'b0, `MIRSE_STAT_OFS, 0);
   endtask

   // Polls until the frame is done, then fetches the received bytes.
   task automatic waitd();
      int t;
      t = 0;
      do stat(); while (rd[3] !== 1'b1 && ++t < 500);
      if (rd[3] !== 1'b1) failures++;
      wb(1'b0, `MIRSE_RDATA_OFS, 0);
   endtask

   task automatic run(input logic [31:0] c, input logic [23:0] a);
      wb(1'b1, `MIRSE_ADDR_OFS, {8'h00, a});
      wb(1'b1, `MIRSE_CTRL_OFS, c);
      waitd();
   endtask

   // Four bytes as the flash holds them, linear or wrapped in dep bytes.
   function automatic logic [31:0] exp4(input logic [23:0] a, input int dep);
      logic [31:0] w;
      logic [23:0] m;
      w = '0;
      m = 24'(dep - 1);
      for (int i = 0; i < 4; i++)
      begin
         w = {w[23:0], a[7:0] ^ 8'h5a};
         a = dep != 0 ? (a & ~m) | ((a + 24'h1) & m) : a + 24'h1;
      end
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("oe", 0, {cs_n, hoe} ^ 5'h10);
      wb(1'b0, 6'h3c, 32'hffffffff);
      chk("unmapped", 0, rd);
      wb(1'b0, `MIRSE_WRAP_OFS, 0);
      chk("wrap reset", 32'h10, rd);
   endtask

   // Dual reads across the top address, short and long dummies.
   task automatic t_dual();
      run(32'h30, 24'hfffffe);
      chk("dual", exp4(24'hfffffe, 0), rd);
      ld <= 1'b1;
      run(32'h230, 24'h0012fe);
      chk("dual long", exp4(24'h0012fe, 0), rd);
      ld <= 1'b0;
   endtask

   task automatic t_quad();
      wb(1'b1, `MIRSE_CFG_OFS, 0);
      wb(1'b1, `MIRSE_CTRL_OFS, 32'h31);
      stat();
      chk("qe refused", 32'h4, rd & 32'h5);
      wb(1'b1, `MIRSE_CFG_OFS, 1);
      run(32'h31, 24'h000abc);
      chk("quad out", exp4(24'h000abc, 0), rd);
   endtask

   // Enter, stay in and leave continuous reads.
   task automatic t_cont();
      run(32'h132, 24'h000100);
      chk("cont 1", exp4(24'h000100, 0), rd);
      wb(1'b1, `MIRSE_CTRL_OFS, 32'h30);
      stat();
      chk("cont st", 32'h6, rd & 32'h6);
      run(32'h132, 24'h000200);
      chk("cont 2", exp4(24'h000200, 0), rd);
      run(32'h32, 24'h000300);
      chk("cont 3", exp4(24'h000300, 0), rd);
      stat();
      chk("cont off", 0, rd[1]);
      run(32'h32, 24'h000400);
      chk("normal", exp4(24'h000400, 0), rd);
   endtask

   task automatic t_wrap();
      for (int c = 0; c < 4; c++)
      begin
         wb(1'b1, `MIRSE_WRAP_OFS, c);
         run(32'h3, 0);
         run(32'h32, 24'(32'h3e + (8 << c)));
         chk("wrap", exp4(24'(32'h3e + (8 << c)), 8 << c), rd);
      end
      wb(1'b1, `MIRSE_WRAP_OFS, 32'h10);
      run(32'h3, 0);
      ld <= 1'b1;
      run(32'h232, 24'h000046);
      chk("no wrap", exp4(24'h000046, 0), rd);
      ld <= 1'b0;
   endtask

   // Write enable, erase, refusal while busy, progress then clear.
   task automatic t_erase();
      run(32'h6, 0);
      chk("idle sr", 0, rd[1:0]);
      run(32'h5, 0);
      run(32'h6, 0);
      chk("wel set", 2, rd[1:0]);
      wb(1'b1, `MIRSE_ADDR_OFS, 32'h001234);
      wb(1'b1, `MIRSE_CTRL_OFS, 32'h4);
      wb(1'b1, `MIRSE_CTRL_OFS, 32'h5);
      stat();
      chk("busy refused", 32'h5, rd & 32'h5);
      waitd();
      run(32'h6, 0);
      chk("wip set", 3, rd[1:0]);
      repeat (300) @(posedge clk);
      run(32'h6, 0);
      chk("wip clear", 0, rd[1:0]);
   endtask

   task automatic summarize();
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_dual();
      t_quad();
      t_cont();
      t_wrap();
      t_erase();
      summarize();
   end

   // Watchdog: the whole sequence needs well under half this span.
   initial
   begin
      repeat (60000) @(posedge clk);
      failures++;
      summarize();
   end
endmodule
`default_nettype wire
